// [acm_map.svh]
`ifndef ACM_MAP_SVH
`define ACM_MAP_SVH
// Register byte addresses
`define ACM_ADDR_DATA   12'hFB8
`define ACM_ADDR_KEY    12'hFB9
`define ACM_ADDR_CTRL   12'hFBA
`define ACM_ADDR_STAT   12'hFBB
// Mode field encodings
`define ACM_MODE_ECB    2'h0
`define ACM_MODE_OFB    2'h1
`define ACM_MODE_CBC    2'h2
`define ACM_MODE_DERIVE 2'h3
// Status write bit positions
`define ACM_ST_BUSY     0
`define ACM_ST_ERROR    1
// Reset values, counts and cipher constants
`define ACM_CTRL_RESET  8'h00
`define ACM_LAST_BYTE   4'hF
`define ACM_ROUNDS      4'hA
`define ACM_RCON_INIT   8'h01
`define ACM_SBOX_AFFINE 8'h63
`define ACM_GF_POLY     8'h1B
`endif

// [acm_pkg.sv]
package acm_pkg;
`include "acm_map.svh"
	// Mode field values
	typedef enum logic [1:0] {
		ACM_ECB    = `ACM_MODE_ECB,
		ACM_OFB    = `ACM_MODE_OFB,
		ACM_CBC    = `ACM_MODE_CBC,
		ACM_DERIVE = `ACM_MODE_DERIVE
	} acm_mode_e;
	// Control register layout
	typedef struct packed {
		logic      auto_go_disable;
		logic      rsvd;
		logic      irq_en;
		acm_mode_e mode;
		logic      iv_window_select;
		logic      decrypt;
		logic      accel_enable;
	} acm_ctrl_s;
	// Status register layout
	typedef struct packed {
		logic [2:0] rsvd;
		logic       key_loaded_flag;
		logic       iv_loaded_flag;
		logic       block_loaded_flag;
		logic       error;
		logic       busy;
	} acm_stat_s;
	// Engine states
	typedef enum logic {ACM_IDLE, ACM_RUN} acm_state_e;
endpackage

// [acm_core.sv]
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "acm_map.svh"
module acm_core
	import acm_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            rx_req,
	output logic            tx_req,
	output logic            done_irq
);
	// GF(2^8) doubling
	function automatic logic [7:0] xt(input logic [7:0] b);
		return {b[6:0], 1'b0} ^ (b[7] ? `ACM_GF_POLY : 8'h00);
	endfunction
	// GF(2^8) product; a is consumed as the running multiple
	function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		p = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) begin
				p = p ^ a;
			end
			a = xt(a);
		end
		return p;
	endfunction
	// Substitution: inverse by b^254, then affine map
	function automatic logic [7:0] sbox(input logic [7:0] b);
		logic [7:0] r;
		r = 8'h01;
		for (int i = 1; i < 8; i++) begin
			b = gmul(b, b);
			r = gmul(r, b);
		end
		return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]}
			^ {r[3:0], r[7:4]} ^ `ACM_SBOX_AFFINE;
	endfunction
	// One cipher round; byte i of the state at bits 127-8i
	function automatic logic [127:0] aes_round(input logic [127:0] st,
		input logic [127:0] rk, input logic last);
		logic [7:0]   t [16];
		logic [7:0]   a0, a1, a2, a3;
		logic [127:0] o;
		for (int c = 0; c < 4; c++) begin
			for (int r = 0; r < 4; r++) begin
				t[r + 4 * c] = sbox(st[127 - 8 * (r + 4 * ((c + r) % 4)) -: 8]);
			end
		end
		for (int c = 0; c < 4; c++) begin
			a0 = t[4 * c];
			a1 = t[4 * c + 1];
			a2 = t[4 * c + 2];
			a3 = t[4 * c + 3];
			o[127 - 32 * c -: 32] = last ? {a0, a1, a2, a3} : {xt(a0) ^ xt(a1) ^ a1 ^ a2 ^ a3,
				a0 ^ xt(a1) ^ xt(a2) ^ a2 ^ a3,
				a0 ^ a1 ^ xt(a2) ^ xt(a3) ^ a3,
				xt(a0) ^ a0 ^ a1 ^ a2 ^ xt(a3)};
		end
		return o ^ rk;
	endfunction
	// Next round key of the expansion
	function automatic logic [127:0] key_step(input logic [127:0] rk,
		input logic [7:0] rc);
		logic [31:0] t, w0, w1, w2, w3;
		t = {sbox(rk[23:16]) ^ rc, sbox(rk[15:8]), sbox(rk[7:0]), sbox(rk[31:24])};
		w0 = rk[127:96] ^ t;
		w1 = rk[95:64] ^ w0;
		w2 = rk[63:32] ^ w1;
		w3 = rk[31:0] ^ w2;
		return {w0, w1, w2, w3};
	endfunction
	acm_ctrl_s    ctrl;         // Control register
	acm_state_e   state;        // Engine state
	logic         busy;         // Go / busy bit
	logic         error;        // Blocked write seen
	logic         key_ld;       // Key loaded flag
	logic         iv_ld;        // Vector loaded flag
	logic         blk_ld;       // Block loaded flag
	logic         tx_pend;      // Result waiting to be read
	logic         done_pulse;   // Completion, one cycle
	logic         derive_ok;    // Key was loaded at derive start
	logic [127:0] key;          // Loaded key
	logic [127:0] iv;           // Stored vector
	logic [127:0] dbuf;         // Data in / result out
	logic [127:0] st;           // Cipher state
	logic [127:0] rk;           // Current round key
	logic [7:0]   rcon;         // Round constant
	logic [3:0]   round;        // Round number
	logic [3:0]   key_cnt;      // Key bytes written
	logic [3:0]   iv_cnt;       // Vector bytes written
	logic [3:0]   din_cnt;      // Data bytes written
	logic [3:0]   dout_cnt;     // Data bytes read
	logic [7:0]   next_rdata;   // Read mux
	// Address decode; shared address split by vector select
	wire hit_data   = reg_addr == `ACM_ADDR_DATA;
	wire win_data   = hit_data & ~ctrl.iv_window_select;
	wire win_iv     = hit_data & ctrl.iv_window_select;
	wire wr_key     = reg_wr & (reg_addr == `ACM_ADDR_KEY);
	wire wr_ctrl    = reg_wr & (reg_addr == `ACM_ADDR_CTRL);
	wire wr_stat    = reg_wr & (reg_addr == `ACM_ADDR_STAT);
	wire wr_data    = reg_wr & win_data;
	wire wr_iv      = reg_wr & win_iv;
	wire rd_data    = reg_rd & win_data;
	// Window writes while running are refused
	wire blocked    = busy & (wr_data | wr_iv | wr_key);
	wire load_data  = wr_data & ~busy;
	wire load_iv    = wr_iv & ~busy;
	wire load_key   = wr_key & ~busy;
	wire clr        = sys_rst | ~ctrl.accel_enable;
	wire new_derive = wr_ctrl & (reg_wdata[4:3] == `ACM_MODE_DERIVE);
	wire leave_der  = wr_ctrl & (ctrl.mode == ACM_DERIVE) & ~new_derive;
	wire chain      = (ctrl.mode == ACM_OFB) | (ctrl.mode == ACM_CBC);
	wire data_full  = load_data & (din_cnt == `ACM_LAST_BYTE);
	wire [127:0] next_dbuf = {dbuf[119:0], reg_wdata};
	// Start paths: auto on sixteenth byte, or go bit
	wire auto_go    = data_full & ~ctrl.auto_go_disable & key_ld
		& (iv_ld | ~chain);
	wire man_go     = wr_stat & reg_wdata[`ACM_ST_BUSY];
	wire go         = (auto_go | man_go) & (state == ACM_IDLE) & ctrl.accel_enable;
	// First block takes the stored vector as chaining value
	wire [127:0] blk_src = data_full ? next_dbuf : dbuf; // Arriving block only on auto start
	wire [127:0] in_blk = (ctrl.mode == ACM_OFB) ? iv :
		(ctrl.mode == ACM_CBC) ? (blk_src ^ iv) : blk_src;
	wire [127:0] next_rk = key_step(rk, rcon);
	wire [127:0] next_st = aes_round(st, next_rk, round == `ACM_ROUNDS);
	wire finishing = (state == ACM_RUN) & (round == `ACM_ROUNDS);
	// Result: feedback XOR, plain cipher, or derived key
	wire [127:0] result = (ctrl.mode == ACM_OFB) ? (next_st ^ dbuf) :
		(ctrl.mode == ACM_DERIVE) ? (derive_ok ? next_rk : '0) : next_st;
	// Byte select, most significant byte first
	wire [6:0] sel = {dout_cnt, 3'h0};
	wire [7:0] dout_byte = dbuf[~sel -: 8];
	// Control register
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl <= `ACM_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= reg_wdata & 8'hBF;
		end
	end
	// Engine sequencing
	always_ff @(posedge core_clk) begin
		if (clr) begin
			state <= ACM_IDLE;
			round <= 4'h0;
		end else if (go) begin
			state <= ACM_RUN;
			round <= 4'h1;
		end else if (finishing) begin
			state <= ACM_IDLE;
		end else if (state == ACM_RUN) begin
			round <= round + 4'h1;
		end
	end
	// Cipher datapath, one round per clock
	always_ff @(posedge core_clk) begin
		if (go) begin
			st <= in_blk ^ key;
			rk <= key;
			rcon <= `ACM_RCON_INIT;
			derive_ok <= key_ld;
		end else if (state == ACM_RUN) begin
			st <= next_st;
			rk <= next_rk;
			rcon <= xt(rcon);
		end
	end
	// Busy follows engine; completion drops it
	always_ff @(posedge core_clk) begin
		if (clr) begin
			busy <= 1'b0;
			done_pulse <= 1'b0;
		end else begin
			busy <= go | (busy & ~finishing);
			done_pulse <= finishing & ctrl.irq_en;
		end
	end
	// Error flag: set wins over write-one clear
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			error <= 1'b0;
		end else if (blocked) begin
			error <= 1'b1;
		end else if (wr_stat & reg_wdata[`ACM_ST_ERROR]) begin
			error <= 1'b0;
		end
	end
	// Key window and its flag
	always_ff @(posedge core_clk) begin
		if (clr) begin
			key <= '0;
			key_cnt <= 4'h0;
			key_ld <= 1'b0;
		end else if (load_key) begin
			key <= {key[119:0], reg_wdata};
			key_cnt <= key_cnt + 4'h1;
			key_ld <= key_cnt == `ACM_LAST_BYTE;
		end else if (new_derive) begin
			key_cnt <= 4'h0;
			key_ld <= 1'b0;
		end
	end
	// Vector window; chaining overwrites it, flag kept
	always_ff @(posedge core_clk) begin
		if (clr) begin
			iv <= '0;
			iv_cnt <= 4'h0;
			iv_ld <= 1'b0;
		end else if (load_iv) begin
			iv <= {iv[119:0], reg_wdata};
			iv_cnt <= iv_cnt + 4'h1;
			iv_ld <= iv_cnt == `ACM_LAST_BYTE;
		end else if (finishing & chain) begin
			iv <= next_st;
		end
	end
	// Data window: load, result, hide derived key
	always_ff @(posedge core_clk) begin
		if (clr) begin
			dbuf <= '0;
		end else if (finishing) begin
			dbuf <= result;
		end else if (leave_der) begin
			dbuf <= '0;
		end else if (load_data) begin
			dbuf <= next_dbuf;
		end
	end
	// Data counters and load / result flags
	always_ff @(posedge core_clk) begin
		if (clr) begin
			din_cnt <= 4'h0;
			dout_cnt <= 4'h0;
			blk_ld <= 1'b0;
			tx_pend <= 1'b0;
		end else if (finishing) begin
			dout_cnt <= 4'h0;
			blk_ld <= 1'b0;
			tx_pend <= 1'b1;
		end else begin
			if (load_data) begin
				din_cnt <= din_cnt + 4'h1;
			end
			if (data_full) begin
				blk_ld <= 1'b1;
			end
			if (rd_data) begin
				dout_cnt <= dout_cnt + 4'h1;
			end
			if (rd_data & (dout_cnt == `ACM_LAST_BYTE)) begin
				tx_pend <= 1'b0;
			end
		end
	end
	// Read mux; vector and key windows are write-only
	always_comb begin
		next_rdata = 8'h00;
		if (reg_rd & win_data) begin
			next_rdata = dout_byte;
		end else if (reg_rd & (reg_addr == `ACM_ADDR_CTRL)) begin
			next_rdata = ctrl;
		end else if (reg_rd & (reg_addr == `ACM_ADDR_STAT)) begin
			next_rdata = {3'h0, key_ld, iv_ld, blk_ld, error, busy};
		end
	end
	// Read data one cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_rdata;
		end
	end
	// Requests and interrupt muted under vector select
	assign rx_req = ctrl.accel_enable & key_ld & ~blk_ld & ~busy & ~tx_pend
		& (iv_ld | ~chain) & ~ctrl.iv_window_select;
	assign tx_req = tx_pend & ~ctrl.iv_window_select;
	assign done_irq = done_pulse & ~ctrl.iv_window_select;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_run;
		busy [*8] ##1 busy [*2];
	endsequence
	sequence s_done;
		!busy && !blk_ld;
	endsequence
	chk_busy_span: assert property (go && !wr_ctrl |=> s_run ##1 s_done)
		else $error("busy span wrong");
	chk_ofb_chain: assert property (finishing && ctrl.mode == ACM_OFB
		|=> iv == $past(next_st)) else $error("ofb vector not chained");
	chk_ofb_xor: assert property (finishing && ctrl.mode == ACM_OFB
		|=> dbuf == ($past(next_st) ^ $past(dbuf))) else $error("ofb output wrong");
	chk_cbc_chain: assert property (finishing && ctrl.mode == ACM_CBC
		|=> iv == dbuf) else $error("cbc vector not ciphertext");
	chk_ivsel_quiet: assert property (ctrl.iv_window_select
		|-> !rx_req && !tx_req && !done_irq) else $error("request under vector select");
	chk_iv_loaded_flag_hold: assert property (iv_ld && !wr_iv && ctrl.accel_enable
		|=> iv_ld) else $error("vector flag dropped");
	chk_derive_keyclr: assert property (new_derive && !busy
		|=> !key_ld) else $error("key flag not cleared");
	chk_blocked_write: assert property (blocked && ctrl.accel_enable
		|=> error && $stable(key)) else $error("blocked write took effect");
	chk_disable_clear: assert property (!ctrl.accel_enable
		|=> !key_ld && !iv_ld && !blk_ld) else $error("flags survive disable");
endmodule

// [acm_host.sv]
`timescale 1ns/1ps
`include "acm_map.svh"
// Host model: CPU or DMA master on the register port
module acm_host
	import acm_pkg::*;
(
	input  wire logic        core_clk,
	output logic      [11:0] reg_addr,
	output logic       [7:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic  [7:0] reg_rdata
);
	int poll_miss = 0; // Busy polls that ran out
	// Idle bus from time zero
	initial begin
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One write; a spare edge keeps strobes from colliding
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	// One read; data taken in the cycle after the strobe
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		d = reg_rdata;
	endtask
	// Sixteen bytes, most significant first
	task automatic wr16(input logic [11:0] a, input logic [127:0] v);
		for (int i = 15; i >= 0; i--) begin
			wr(a, v[8*i +: 8]);
		end
	endtask
	// Sixteen result bytes from the data window
	task automatic rd16(output logic [127:0] v);
		logic [7:0] b;
		for (int i = 15; i >= 0; i--) begin
			rd(`ACM_ADDR_DATA, b);
			v[8*i +: 8] = b;
		end
	endtask
	// Control write: enabled, interrupt on, decrypt bit kept clear
	task automatic ctl(input logic [1:0] m, input logic ivs, input logic man);
		wr(`ACM_ADDR_CTRL, {man, 2'b01, m, ivs, 2'b01});
	endtask
	// Mode, key, then vector; select is left set for the caller
	task automatic setup(input logic [1:0] m, input logic man, input logic [127:0] k, iv);
		ctl(m, 1'b0, man);
		wr16(`ACM_ADDR_KEY, k);
		ctl(m, 1'b1, man);
		wr16(`ACM_ADDR_DATA, iv);
	endtask
	// Poll busy until clear, bounded
	task automatic waitd();
		logic [7:0] s;
		s = 8'h01;
		for (int n = 0; n < 20 && s[0] !== 1'b0; n++) begin
			rd(`ACM_ADDR_STAT, s);
		end
		if (s[0] !== 1'b0) begin
			poll_miss++;
			$display("FAIL %0t busy never cleared", $time);
		end
	endtask
	// Data in, optional go, wait, result out
	task automatic blk(input logic man, input logic [127:0] d, output logic [127:0] r);
		wr16(`ACM_ADDR_DATA, d);
		if (man) wr(`ACM_ADDR_STAT, 8'h01);
		waitd();
		rd16(r);
	endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
`include "acm_map.svh"
// Bench for the chaining cipher core
module tb_top
	import acm_pkg::*;
;
	logic         core_clk;
	logic         sys_rst;
	logic  [11:0] reg_addr;
	logic   [7:0] reg_wdata;
	logic         reg_wr;
	logic         reg_rd;
	logic   [7:0] reg_rdata;
	logic         rx_req;
	logic         tx_req;
	logic         done_irq;
	int           fail_count;
	int           check_count;
	int           irq_cnt = 0;
	int           n;
	int           cyc = 0;
	logic [127:0] r1;
	logic [127:0] r2;
	logic [127:0] x;
	logic   [7:0] s;
	// Standard cipher test vectors
	localparam logic [127:0] KEY = 128'h000102030405060708090A0B0C0D0E0F;
	localparam logic [127:0] PT  = 128'h00112233445566778899AABBCCDDEEFF;
	localparam logic [127:0] CT  = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
	localparam logic [127:0] RK  = 128'h13111D7FE3944A17F307A78B4D2B30C5;
	localparam logic [127:0] IV  = 128'hF0E1D2C3B4A5968778695A4B3C2D1E0F;
	// 100 MHz clock
	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;
	acm_core u_acm_core (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_req(rx_req), .tx_req(tx_req), .done_irq(done_irq));
	acm_host u_acm_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	// Count completion pulses; cut a hang short
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (done_irq === 1'b1) irq_cnt <= irq_cnt + 1;
		if (cyc == 20000) begin
			fail_count++;
			test_done();
		end
	end
	// Compare and count
	task automatic chk(input logic [127:0] got, exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Status byte into s
	task automatic st();
		u_acm_host.rd(`ACM_ADDR_STAT, s);
	endtask
	// Counts, verdict, end of run
	task automatic test_done();
		fail_count += u_acm_host.poll_miss;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Main sequence
	initial begin
		fail_count = 0;
		check_count = 0;
		sys_rst = 1'b1;
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		// Codebook block, manual start
		u_acm_host.ctl(ACM_ECB, 1'b0, 1'b1);
		u_acm_host.wr16(`ACM_ADDR_KEY, KEY);
		u_acm_host.blk(1'b1, PT, r1);
		chk(irq_cnt, 1);
		chk(r1, CT);
		chk({tx_req, rx_req}, 2'b01);
		$display("end codebook");
		// Key derivation
		u_acm_host.ctl(ACM_DERIVE, 1'b0, 1'b1);
		st();
		chk(s[4], 1'b0);
		u_acm_host.wr16(`ACM_ADDR_KEY, KEY);
		u_acm_host.blk(1'b1, PT, r1);
		chk(r1, RK);
		u_acm_host.blk(1'b1, ~PT, r1);
		chk(r1, RK);
		u_acm_host.ctl(ACM_DERIVE, 1'b0, 1'b1);
		u_acm_host.blk(1'b1, PT, r1);
		chk(r1, 128'h0);
		u_acm_host.wr16(`ACM_ADDR_KEY, KEY);
		u_acm_host.wr16(`ACM_ADDR_DATA, PT);
		u_acm_host.wr(`ACM_ADDR_STAT, 8'h01);
		u_acm_host.waitd();
		u_acm_host.ctl(ACM_ECB, 1'b0, 1'b1);
		u_acm_host.rd16(r1);
		chk(r1, 128'h0);
		$display("end derive");
		// Output feedback, auto start, two chained blocks
		u_acm_host.setup(ACM_OFB, 1'b0, KEY, IV);
		chk(rx_req, 1'b0);
		u_acm_host.ctl(ACM_OFB, 1'b0, 1'b0);
		chk(rx_req, 1'b1);
		u_acm_host.blk(1'b0, PT, r1);
		u_acm_host.blk(1'b0, CT, r2);
		st();
		chk(s[3], 1'b1);
		u_acm_host.ctl(ACM_ECB, 1'b0, 1'b1);
		u_acm_host.blk(1'b1, IV, x);
		chk(x, r1 ^ PT);
		u_acm_host.blk(1'b1, x, x);
		chk(x, r2 ^ CT);
		$display("end feedback");
		// Block chaining with a blocked write mid-run
		u_acm_host.setup(ACM_CBC, 1'b1, KEY, IV);
		u_acm_host.ctl(ACM_CBC, 1'b0, 1'b1);
		u_acm_host.blk(1'b1, PT, r1);
		u_acm_host.wr16(`ACM_ADDR_DATA, CT);
		u_acm_host.wr(`ACM_ADDR_STAT, 8'h01);
		u_acm_host.wr(`ACM_ADDR_DATA, 8'hA5);
		st();
		chk(s[1:0], 2'b11);
		u_acm_host.waitd();
		u_acm_host.rd16(r2);
		u_acm_host.wr(`ACM_ADDR_STAT, 8'h02);
		st();
		chk(s[1], 1'b0);
		u_acm_host.ctl(ACM_ECB, 1'b0, 1'b1);
		u_acm_host.blk(1'b1, PT ^ IV, x);
		chk(x, r1);
		u_acm_host.blk(1'b1, CT ^ r1, x);
		chk(x, r2);
		$display("end chaining");
		// Vector routing, silenced completion, disable
		u_acm_host.ctl(ACM_CBC, 1'b1, 1'b1);
		u_acm_host.wr(`ACM_ADDR_DATA, 8'h3C);
		st();
		chk(s[4:2], 3'b100);
		n = irq_cnt;
		u_acm_host.wr(`ACM_ADDR_STAT, 8'h01);
		u_acm_host.waitd();
		chk({tx_req, rx_req}, 2'b00);
		chk(irq_cnt, n);
		u_acm_host.wr(`ACM_ADDR_CTRL, 8'h00);
		st();
		chk(s[4:2], 3'b000);
		$display("end select and disable");
		test_done();
	end
endmodule
